// >>> merr_consts.vh
`ifndef MERR_CONSTS_VH
`define MERR_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MERR_OFF_CTRL 8'h00
`define MERR_OFF_STATUS 8'h04
`define MERR_OFF_IRQ_STAT 8'h08
`define MERR_OFF_IRQ_EN 8'h0C
`define MERR_OFF_IRQ_CLR 8'h10
`define MERR_OFF_COMP 8'h14
`define MERR_OFF_OPEN_VAL 8'h18
`define MERR_OFF_SHORT_VAL 8'h1C
`define MERR_OFF_LOAD_MIN 8'h20
`define MERR_OFF_LOAD_MAX 8'h24
`define MERR_OFF_LOAD_VAL 8'h28
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MERR_CTRL_RST 32'h0000_0000
`define MERR_IRQ_EN_RST 9'h000
`define MERR_LOAD_MIN_RST 32'h0000_0000
`define MERR_LOAD_MAX_RST 32'hFFFF_FFFF
// compensation limit, ohms
`define MERR_COMP_LIMIT_OHM 32'h0000_03E8
// ----------------------------------------------------------------
// readout codes (0 = normal value shown)
// ----------------------------------------------------------------
`define MERR_CODE_NONE 4'h0
`define MERR_CODE_SAMPLE 4'h1
`define MERR_CODE_TIMEOUT 4'h2
`define MERR_CODE_CURRENT 4'h3
`define MERR_CODE_VOLTAGE 4'h4
`define MERR_CODE_LEVEL 4'h5
`define MERR_CODE_OPEN 4'h6
`define MERR_CODE_SHORT 4'h7
`define MERR_CODE_LOAD 4'h8
// ----------------------------------------------------------------
// error flag bit positions
// ----------------------------------------------------------------
`define MERR_B_SAMPLE 0
`define MERR_B_TIMEOUT 1
`define MERR_B_CURRENT 2
`define MERR_B_VOLTAGE 3
`define MERR_B_LOWC 4
`define MERR_B_LEVEL 5
`define MERR_B_OPEN 6
`define MERR_B_SHORT 7
`define MERR_B_LOAD 8
`define MERR_NFLAGS 9
// ctrl bits
`define MERR_CTRL_SWTRIG 0
`define MERR_CTRL_SWCOMP 1
`endif

// >>> merr_flag_bank.v
`include "merr_consts.vh"
module merr_flag_bank #(
  parameter N = 9
) (
  clk, // clock
  rstN, // synced reset, active low
  clear, // clear all flags
  setVec, // set requests
  flags // held flags
);
  input wire clk; // clock
  input wire rstN; // reset
  input wire clear; // clear
  input wire [N-1:0] setVec; // sets
  output wire [N-1:0] flags; // flags
  genvar i;
  // ------------------------------------------------------------
  // per-measurement flags, set beats clear
  // ------------------------------------------------------------
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_flag
      reg held_reg;
      always @(posedge clk or negedge rstN)
      begin
        if (!rstN)
          held_reg <= 1'b0;
        else if (setVec[i])
          held_reg <= 1'b1;
        else if (clear)
          held_reg <= 1'b0;
      end
      assign flags[i] = held_reg;
    end
  endgenerate
endmodule // merr_flag_bank

// >>> merr_reporter.v
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "merr_consts.vh"
module merr_reporter (
  input wire clk, // 20 MHz clock
  input wire nrst, // async reset, active low
  input wire trigIn, // trigger pulse from sequencing port
  input wire measStart, // measurement began pulse
  input wire measDone, // measurement complete pulse
  input wire adcFail, // conversion abnormal
  input wire trigTimeout, // measurement did not start after trigger
  input wire currentOut, // current outside range
  input wire voltageLow, // terminal voltage low
  input wire lowCReject, // value abnormally below range
  input wire levelFluct, // level monitor fluctuates
  input wire compDone, // compensation value acquired pulse
  input wire [1:0] compKind, // 0 open, 1 short, 2 load
  input wire [31:0] compValue, // compensation value, ohms or counts
  input wire normAbove, // ordinary above limit judgment
  input wire normOutOfBins, // ordinary out-of-bins judgment
  input wire [7:0] awaddr, // axi write address
  input wire awvalid, // axi
  output wire awready, // axi
  input wire [31:0] wdata, // axi
  input wire [3:0] wstrb, // axi
  input wire wvalid, // axi
  output wire wready, // axi
  output wire [1:0] bresp, // axi
  output wire bvalid, // axi
  input wire bready, // axi
  input wire [7:0] araddr, // axi
  input wire arvalid, // axi
  output wire arready, // axi
  output wire [31:0] rdata, // axi
  output wire [1:0] rresp, // axi
  output wire rvalid, // axi
  input wire rready, // axi
  output wire [3:0] readoutCode, // main readout code
  output wire errOut, // error line on sequencing port
  output wire aboveLimitJudgment, // above limit judgment out
  output wire outOfBins, // out-of-bins judgment out
  output wire irq // interrupt, level
);

  localparam N = `MERR_NFLAGS;
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_MEAS = 3'b100;

  reg [1:0] rstSync_reg;
  reg [1:0] bresp_reg, rresp_reg;
  reg [2:0] state_reg, state_next;
  reg [3:0] code_reg, codeSel, wStrb_reg;
  reg [7:0] awAddr_reg;
  reg [31:0] ctrl_reg, loadMin_reg, loadMax_reg, openVal_reg, shortVal_reg, loadVal_reg;
  reg [31:0] wData_reg, rdata_reg, rdSel;
  reg [N-1:0] irqStat_reg, irqEn_reg;
  reg errOut_reg, above_reg, out_reg, awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg, rdOk;
  wire rstN, trig, doWrite, swComp;
  wire [N-1:0] setVec, flags, clrVec;
  wire [31:0] clrWord, irqEnWord;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rstSync_reg <= 2'b00;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rstN = rstSync_reg[1];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[k*8 +: 8] = data[k*8 +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // measurement sequence
  // ------------------------------------------------------------
  assign trig = trigIn | (doWrite && awAddr_reg == `MERR_OFF_CTRL && wStrb_reg[0] && wData_reg[`MERR_CTRL_SWTRIG]);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (trig) state_next = ST_WAIT;
      ST_WAIT:
      begin
        if (measStart)
          state_next = ST_MEAS;
        else if (trigTimeout)
          state_next = ST_IDLE;
      end
      ST_MEAS: if (measDone) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ------------------------------------------------------------
  // error detection
  // ------------------------------------------------------------
  assign swComp = ctrl_reg[`MERR_CTRL_SWCOMP];
  assign setVec[`MERR_B_SAMPLE] = adcFail && state_reg == ST_MEAS;
  assign setVec[`MERR_B_TIMEOUT] = trigTimeout && state_reg == ST_WAIT;
  assign setVec[`MERR_B_CURRENT] = currentOut && state_reg == ST_MEAS;
  assign setVec[`MERR_B_VOLTAGE] = voltageLow && state_reg == ST_MEAS;
  assign setVec[`MERR_B_LOWC] = lowCReject && state_reg == ST_MEAS;
  assign setVec[`MERR_B_LEVEL] = levelFluct && state_reg == ST_MEAS;
  assign setVec[`MERR_B_OPEN] = compDone && !swComp && compKind == 2'd0
    && compValue < `MERR_COMP_LIMIT_OHM;
  assign setVec[`MERR_B_SHORT] = compDone && !swComp && compKind == 2'd1
    && compValue > `MERR_COMP_LIMIT_OHM;
  assign setVec[`MERR_B_LOAD] = compDone && !swComp && compKind == 2'd2
    && (compValue < loadMin_reg || compValue > loadMax_reg);

  merr_flag_bank #(
    .N(N)
  ) u_flags (
    .clk(clk),
    .rstN(rstN),
    .clear(trig && state_reg == ST_IDLE),
    .setVec(setVec),
    .flags(flags)
  );

  // ------------------------------------------------------------
  // priority readout and sequencing outputs
  // ------------------------------------------------------------
  always @*
  begin
    codeSel = `MERR_CODE_NONE;
    if (flags[`MERR_B_SAMPLE]) codeSel = `MERR_CODE_SAMPLE;
    else if (flags[`MERR_B_TIMEOUT]) codeSel = `MERR_CODE_TIMEOUT;
    else if (flags[`MERR_B_CURRENT]) codeSel = `MERR_CODE_CURRENT;
    else if (flags[`MERR_B_VOLTAGE]) codeSel = `MERR_CODE_VOLTAGE;
    else if (flags[`MERR_B_LEVEL]) codeSel = `MERR_CODE_LEVEL;
    else if (flags[`MERR_B_OPEN]) codeSel = `MERR_CODE_OPEN;
    else if (flags[`MERR_B_SHORT]) codeSel = `MERR_CODE_SHORT;
    else if (flags[`MERR_B_LOAD]) codeSel = `MERR_CODE_LOAD;
  end

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      code_reg <= `MERR_CODE_NONE;
      errOut_reg <= 1'b0;
      above_reg <= 1'b0;
      out_reg <= 1'b0;
    end
    else
    begin
      code_reg <= codeSel;
      errOut_reg <= flags[`MERR_B_SAMPLE] | flags[`MERR_B_TIMEOUT] | flags[`MERR_B_VOLTAGE]
        | flags[`MERR_B_LOWC] | flags[`MERR_B_LEVEL];
      if (codeSel != `MERR_CODE_NONE)
      begin
        above_reg <= 1'b1;
        out_reg <= 1'b1;
      end
      else
      begin
        above_reg <= normAbove;
        out_reg <= normOutOfBins;
      end
    end
  end
  assign readoutCode = code_reg;
  assign errOut = errOut_reg;
  assign aboveLimitJudgment = above_reg;
  assign outOfBins = out_reg;

  // ------------------------------------------------------------
  // interrupt status, set beats clear
  // ------------------------------------------------------------
  assign clrWord = merge(32'h0000_0000, wData_reg, wStrb_reg);
  assign clrVec = (doWrite && awAddr_reg == `MERR_OFF_IRQ_CLR) ? clrWord[N-1:0] : {N{1'b0}};
  assign irqEnWord = merge({{(32-N){1'b0}}, irqEn_reg}, wData_reg, wStrb_reg);
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      irqStat_reg <= {N{1'b0}};
    else
      irqStat_reg <= setVec | (irqStat_reg & ~clrVec);
  end
  assign irq = |(irqStat_reg & irqEn_reg);

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  assign awready = !awHeld_reg && !bvalid_reg;
  assign wready = !wHeld_reg && !bvalid_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign arready = !rvalid_reg;

  always @*
  begin
    rdOk = 1'b1;
    case (araddr)
      `MERR_OFF_CTRL: rdSel = ctrl_reg;
      `MERR_OFF_STATUS: rdSel = {13'h0000, code_reg, state_reg, out_reg, above_reg, errOut_reg, flags};
      `MERR_OFF_IRQ_STAT: rdSel = {23'h000000, irqStat_reg};
      `MERR_OFF_IRQ_EN: rdSel = {23'h000000, irqEn_reg};
      `MERR_OFF_IRQ_CLR: rdSel = 32'h0000_0000;
      `MERR_OFF_COMP: rdSel = {23'h000000, flags};
      `MERR_OFF_OPEN_VAL: rdSel = openVal_reg;
      `MERR_OFF_SHORT_VAL: rdSel = shortVal_reg;
      `MERR_OFF_LOAD_MIN: rdSel = loadMin_reg;
      `MERR_OFF_LOAD_MAX: rdSel = loadMax_reg;
      `MERR_OFF_LOAD_VAL: rdSel = loadVal_reg;
      default:
      begin
        rdSel = 32'h0000_0000;
        rdOk = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'b00;
      ctrl_reg <= `MERR_CTRL_RST;
      irqEn_reg <= `MERR_IRQ_EN_RST;
      loadMin_reg <= `MERR_LOAD_MIN_RST;
      loadMax_reg <= `MERR_LOAD_MAX_RST;
      openVal_reg <= 32'h0000_0000;
      shortVal_reg <= 32'h0000_0000;
      loadVal_reg <= 32'h0000_0000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= 2'b00;
        case (awAddr_reg)
          `MERR_OFF_CTRL: ctrl_reg <= merge(ctrl_reg, wData_reg, wStrb_reg) & 32'h0000_0002;
          `MERR_OFF_IRQ_EN: irqEn_reg <= irqEnWord[N-1:0];
          `MERR_OFF_IRQ_CLR: bresp_reg <= 2'b00;
          `MERR_OFF_COMP:
          begin
            if (wStrb_reg[0] && wData_reg[0])
              openVal_reg <= 32'h0000_0000;
          end
          `MERR_OFF_LOAD_MIN: loadMin_reg <= merge(loadMin_reg, wData_reg, wStrb_reg);
          `MERR_OFF_LOAD_MAX: loadMax_reg <= merge(loadMax_reg, wData_reg, wStrb_reg);
          default: bresp_reg <= 2'b10;
        endcase
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
      if (arvalid && arready)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdSel;
        rresp_reg <= rdOk ? 2'b00 : 2'b10;
      end
      else if (rvalid_reg && rready)
        rvalid_reg <= 1'b0;
      // capture last compensation values
      if (compDone && compKind == 2'd0)
        openVal_reg <= compValue;
      if (compDone && compKind == 2'd1)
        shortVal_reg <= compValue;
      if (compDone && compKind == 2'd2)
        loadVal_reg <= compValue;
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
endmodule // merr_reporter

// >>> merr_reporter_props.sv
// ----------
// checks
// ----------
module merr_reporter_props (
  input wire clk, // clock
  input wire nrst, // reset
  input wire trigIn, // trigger
  input wire adcFail, // error in
  input wire trigTimeout, // error in
  input wire currentOut, // error in
  input wire voltageLow, // error in
  input wire lowCReject, // error in
  input wire levelFluct, // error in
  input wire compDone, // comp strobe
  input wire bvalid, // write response
  input wire normAbove, // judge in
  input wire normOutOfBins, // judge in
  input wire [3:0] readoutCode, // code
  input wire errOut, // error line
  input wire aboveLimitJudgment, // judge
  input wire outOfBins // judge
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [2:0] upCnt_reg;
  wire up = upCnt_reg == 3'h7;
  wire errIn = adcFail | trigTimeout | voltageLow | lowCReject | levelFluct;
  wire anyIn = errIn | currentOut | compDone;
  // settle time after reset release
  always @(posedge clk or negedge nrst)
    if (!nrst)
      upCnt_reg <= 3'h0;
    else if (!up)
      upCnt_reg <= upCnt_reg + 3'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  judge_force_a: assert property (up && readoutCode != 4'h0 |-> aboveLimitJudgment && outOfBins)
    else $error("judgment not forced");
  pass_thru_a: assert property (up && $past(up) && readoutCode == 4'h0 |->
    aboveLimitJudgment == $past(normAbove) && outOfBins == $past(normOutOfBins))
    else $error("judgment not passed");
  err_line_a: assert property (up && (readoutCode == 4'h1 || readoutCode == 4'h2 ||
    readoutCode == 4'h4 || readoutCode == 4'h5) |-> errOut)
    else $error("error line low");
  err_cause_a: assert property (up && $rose(errOut) |->
    $past(errIn) || $past(errIn, 2) || $past(errIn, 3))
    else $error("error line without cause");
  code_cause_a: assert property (up && readoutCode != 4'h0 && $past(readoutCode) == 4'h0 |->
    $past(anyIn) || $past(anyIn, 2) || $past(anyIn, 3))
    else $error("code without cause");
  // a register write may carry the software trigger
  code_hold_a: assert property (up && readoutCode != 4'h0 && !trigIn && !$past(trigIn) && !bvalid |=>
    readoutCode != 4'h0)
    else $error("code dropped");
  err_hold_a: assert property (up && errOut && !trigIn && !$past(trigIn) && !bvalid |=> errOut)
    else $error("error line dropped");
  code_range_a: assert property (up |-> readoutCode <= 4'h8)
    else $error("code out of range");
endmodule // merr_reporter_props
bind merr_reporter merr_reporter_props merr_reporter_props_i (.clk(clk), .nrst(nrst), .trigIn(trigIn),
  .adcFail(adcFail), .trigTimeout(trigTimeout), .currentOut(currentOut), .voltageLow(voltageLow),
  .lowCReject(lowCReject), .levelFluct(levelFluct), .compDone(compDone), .bvalid(bvalid), .normAbove(normAbove),
  .normOutOfBins(normOutOfBins), .readoutCode(readoutCode), .errOut(errOut),
  .aboveLimitJudgment(aboveLimitJudgment), .outOfBins(outOfBins));

// >>> merr_handler_model.sv
// ----------
// handler
// ----------
module merr_handler_model (
  input wire clk, // clock
  input wire fire, // request
  output logic trigIn // trigger pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  initial trigIn = 1'b0;
  // one-cycle trigger per request
  always @(posedge clk)
    trigIn <= fire && !trigIn;
endmodule // merr_handler_model

// >>> merr_reporter_tb.sv
// ----------
// bench
// ----------
module merr_reporter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, fire = 0, measStart = 0, measDone = 0, adcFail = 0, trigTimeout = 0;
  logic currentOut = 0, voltageLow = 0, lowCReject = 0, levelFluct = 0, compDone = 0;
  logic normAbove = 0, normOutOfBins = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] compKind = 0;
  logic [3:0] wstrb = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] compValue = 0, wdata = 0;
  logic trigIn, awready, wready, bvalid, arready, rvalid, errOut, aboveLimitJudgment, outOfBins, irq;
  logic [1:0] bresp, rresp;
  logic [3:0] readoutCode;
  logic [31:0] rdata;
  int mismatches, checked, seed = 32'h0F590F09;
  int expQ[$];
  int mc[10] = '{1, 2, 4, 8, 16, 32, 61, 44, 40, 48};
  int ck[6] = '{0, 0, 1, 1, 2, 2};
  int cm[6] = '{64, 0, 128, 0, 256, 0};
  logic [31:0] cv[6] = '{32'h3E7, 32'h3E8, 32'h3E9, 32'h3E8, 32'hF, 32'h20};
  merr_handler_model merr_handler_model_i (.clk(clk), .fire(fire), .trigIn(trigIn));
  merr_reporter merr_reporter_i (.clk(clk), .nrst(nrst), .trigIn(trigIn), .measStart(measStart),
    .measDone(measDone), .adcFail(adcFail), .trigTimeout(trigTimeout), .currentOut(currentOut),
    .voltageLow(voltageLow), .lowCReject(lowCReject), .levelFluct(levelFluct), .compDone(compDone),
    .compKind(compKind), .compValue(compValue), .normAbove(normAbove), .normOutOfBins(normOutOfBins),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .readoutCode(readoutCode), .errOut(errOut),
    .aboveLimitJudgment(aboveLimitJudgment), .outOfBins(outOfBins), .irq(irq));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    check(bresp, r);
    tick(1);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    check(rdata, d);
    check(rresp, r);
    tick(1);
  endtask
  // expected readout from the flag mask
  task chk_out(input int m);
    int c;
    c = m[0] ? 1 : m[1] ? 2 : m[2] ? 3 : m[3] ? 4 : m[5] ? 5 : m[6] ? 6 : m[7] ? 7 : m[8] ? 8 : 0;
    check(readoutCode, c);
    check(errOut, |(m & 9'h03B));
    check(aboveLimitJudgment, c ? 1'b1 : normAbove);
    check(outOfBins, c ? 1'b1 : normOutOfBins);
  endtask
  task meas(input int m);
    expQ.push_back(m);
    fire <= 1;
    {normAbove, normOutOfBins} <= 2'($random(seed));
    @(posedge clk);
    fire <= 0;
    tick(3);
    if (m[1])
    begin
      trigTimeout <= 1;
      tick(1);
      trigTimeout <= 0;
    end
    else
    begin
      measStart <= 1;
      tick(1);
      measStart <= 0;
      {adcFail, currentOut, voltageLow, lowCReject, levelFluct} <= {m[0], m[2], m[3], m[4], m[5]};
      tick(1);
      measDone <= 1;
      tick(1);
      measDone <= 0;
      {adcFail, currentOut, voltageLow, lowCReject, levelFluct} <= 5'h00;
    end
    tick(3);
    chk_out(expQ.pop_front());
  endtask
  task comp(input int k, input logic [31:0] v, input int m);
    meas(0);
    compDone <= 1; compKind <= 2'(k); compValue <= v;
    tick(1);
    compDone <= 0;
    tick(3);
    chk_out(m);
  endtask
  initial
  begin
    tick(10);
    check(readoutCode, 0);
    tick(10);
    nrst <= 1;
    tick(4);
    check(errOut, 0);
    axr(8'h00, 0, 0); axr(8'h24, 32'hFFFFFFFF, 0); axr(8'h0C, 0, 0); axr(8'h3C, 0, 2);
    axw(8'h3C, 1, 2); axw(8'h20, 32'h10, 0); axr(8'h20, 32'h10, 0);
    foreach (mc[i]) meas(mc[i]);
    repeat (8) meas($random(seed) & 9'h03D);
    foreach (ck[i]) comp(ck[i], cv[i], cm[i]);
    axw(8'h10, 32'h1FF, 0); axw(8'h0C, 1, 0);
    meas(1);
    check(irq, 1);
    axr(8'h08, 1, 0); axw(8'h10, 1, 0);
    check(irq, 0);
    axw(8'h0C, 0, 0);
    meas(1);
    check(irq, 0);
    axr(8'h08, 1, 0);
    // software trigger clears the sample error, compensation checks suppressed
    axw(8'h00, 32'h3, 0);
    comp(0, 32'h5, 0);
    axr(8'h00, 32'h2, 0);
    axw(8'h00, 0, 0);
    comp(0, 32'h5, 64);
    end_sim();
  end
  initial
  begin
    tick(20000);
    mismatches++;
    end_sim();
  end
endmodule // merr_reporter_tb
